// *** src/shs_top.sv ***
// sync holdover supervisor: state, RF gate, port choice, announce filter
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`include "shs_cfg.svh"
module shs_top #(
    parameter int unsigned HOLD_CYC = `SHS_HOLD_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [`SHS_ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // timing recovery and management plane
    input wire logic ref_locked,
    input wire logic accuracy_ok,
    input wire logic mplane_up,
    input wire shs_pkg::shs_ann_s announce,
    // reference detect pins
    input wire logic [`SHS_PORTS-1:0] sync_present,
    // radio outputs
    output logic rf_tx_enable,
    output logic carrier_active,
    output logic free_notify,
    output shs_pkg::shs_state_e sync_state,
    output logic [`SHS_PORT_W-1:0] active_port,
    output logic port_valid
);
    // pins cross in through two flops
    logic [`SHS_PORTS-1:0] pres_meta;
    logic [`SHS_PORTS-1:0] pres;
    logic port_started;
    logic holdover_en;
    logic redun_en;
    logic class_ok;
    logic free_notice;
    logic acc_flag;
    logic [7:0] last_class;
    logic [7:0] last_domain;
    logic [31:0] hold_cnt;
    shs_pkg::shs_state_e next_state;

    // lowest numbered port with a reference present
    function automatic logic [`SHS_PORT_W-1:0] first_port(input logic [`SHS_PORTS-1:0] p);
        first_port = '0;
        for (int i = `SHS_PORTS - 1; i >= 0; i--) begin
            if (p[i]) begin
                first_port = `SHS_PORT_W'(i);
            end
        end
    endfunction : first_port

    // register decode
    wire hit_ctrl = addr == `SHS_REG_CTRL;
    wire hit_status = addr == `SHS_REG_STATUS;
    wire hit_notice = addr == `SHS_REG_NOTICE;
    wire hit_last = addr == `SHS_REG_LAST;
    wire hit_list = addr[7:5] == `SHS_LIST_TAG;
    wire wr_ctrl = wr_en && hit_ctrl;
    wire clr_free = wr_en && hit_notice && wr_data[`SHS_NOTICE_FREE];
    wire [8:0] list_rd;
    logic [31:0] reg_rd;
    // list words leave their own register: an or, no extra stage
    assign rd_data = reg_rd | {23'h0, list_rd};

    // announce check only on the active reference port
    wire ann_take = announce.valid && port_valid && announce.port == active_port;
    wire chk_done;
    wire dom_ok;
    wire cls_ok;

    // port choice
    wire any_pres = |pres;
    wire [`SHS_PORT_W-1:0] pick = first_port(pres);
    wire cur_present = pres[active_port];
    wire do_start = !port_started && any_pres;
    wire do_switch = port_started && !cur_present && redun_en && any_pres;

    // sync state machine inputs
    wire ref_usable = port_valid && ref_locked && class_ok;
    wire hold_done = hold_cnt >= HOLD_CYC - 1;
    wire enter_free = next_state == shs_pkg::SHS_FREE && sync_state != shs_pkg::SHS_FREE;
    wire carrier_req = wr_ctrl && wr_data[`SHS_CTRL_CARRIER];
    wire next_rf = carrier_active && mplane_up && sync_state != shs_pkg::SHS_FREE;

    shs_accept_mem u_mem (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en && hit_list),
        .rd_en(rd_en && hit_list),
        .idx(addr[4:2]),
        .wr_data(wr_data[8:0]),
        .rd_data(list_rd),
        .chk_valid(ann_take),
        .chk_domain(announce.domain),
        .chk_class(announce.clock_class),
        .chk_done(chk_done),
        .dom_ok(dom_ok),
        .cls_ok(cls_ok)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pres_meta <= '0;
            pres <= '0;
        end else begin
            pres_meta <= sync_present;
            pres <= pres_meta;
        end
    end

    // no controller sync input exists: radio timing stands alone
    always_comb begin
        next_state = sync_state; // see RULE4
        case (sync_state) // see RULE20
            shs_pkg::SHS_FREE: begin
                if (ref_usable) begin
                    next_state = shs_pkg::SHS_LOCKED;
                end
            end
            shs_pkg::SHS_LOCKED: begin
                if (!ref_usable) begin
                    // holdover only if enabled in the control register
                    next_state = holdover_en ? shs_pkg::SHS_HOLD : shs_pkg::SHS_FREE; // see RULE6
                end
            end
            shs_pkg::SHS_HOLD: begin
                if (ref_usable) begin
                    next_state = shs_pkg::SHS_LOCKED;
                end else if (hold_done) begin
                    next_state = shs_pkg::SHS_FREE; // see RULE7
                end
            end
            default: begin
                next_state = shs_pkg::SHS_FREE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_state <= shs_pkg::SHS_FREE;
            hold_cnt <= '0;
        end else begin
            sync_state <= next_state; // see RULE5
            hold_cnt <= (sync_state == shs_pkg::SHS_HOLD && !hold_done) ? hold_cnt + 32'h1 : '0;
        end
    end

    // reselection after startup only when redundancy is on
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            port_started <= 1'b0;
            active_port <= '0;
            port_valid <= 1'b0;
        end else if (do_start || do_switch) begin
            port_started <= 1'b1; // see RULE12
            active_port <= pick; // see RULE13
            port_valid <= 1'b1;
        end else begin
            port_valid <= port_started && cur_present;
        end
    end

    // class verdict only counts when domain matched
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            class_ok <= 1'b0;
            last_class <= 8'h00;
            last_domain <= 8'h00;
        end else begin
            if (do_switch || !port_valid) begin
                class_ok <= 1'b0;
            end else if (chk_done && dom_ok) begin
                class_ok <= cls_ok; // see RULE17
            end
            if (ann_take) begin
                last_class <= announce.clock_class;
                last_domain <= announce.domain;
            end
        end
    end

    // carriers come back only on an explicit request
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            holdover_en <= 1'b0;
            redun_en <= 1'b0;
            carrier_active <= 1'b0;
            free_notice <= 1'b0;
            free_notify <= 1'b0;
            rf_tx_enable <= 1'b0;
            acc_flag <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                holdover_en <= wr_data[`SHS_CTRL_HOLD_EN];
                redun_en <= wr_data[`SHS_CTRL_REDUN_EN];
            end
            if (enter_free) begin
                carrier_active <= 1'b0; // see RULE16
            end else if (wr_ctrl) begin
                carrier_active <= carrier_req && sync_state != shs_pkg::SHS_FREE;
            end
            // set beats a same-cycle clear
            free_notice <= enter_free || (free_notice && !clr_free); // see RULE16
            free_notify <= enter_free;
            rf_tx_enable <= next_rf && !enter_free; // see RULE19
            acc_flag <= accuracy_ok && sync_state != shs_pkg::SHS_FREE; // see RULE20
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rd <= 32'h0000_0000;
        end else if (!rd_en) begin
            reg_rd <= 32'h0000_0000;
        end else if (hit_ctrl) begin
            reg_rd <= {29'h0, carrier_active, redun_en, holdover_en};
        end else if (hit_status) begin
            reg_rd <= {22'h0, class_ok, port_valid, active_port, rf_tx_enable,
                mplane_up, acc_flag, 1'b0, sync_state};
        end else if (hit_notice) begin
            reg_rd <= {31'h0, free_notice};
        end else if (hit_last) begin
            reg_rd <= {16'h0, last_domain, last_class};
        end else begin
            reg_rd <= 32'h0000_0000;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_class_reject;
        chk_done && dom_ok && !cls_ok && port_valid && !do_switch;
    endsequence

    sequence s_leave_locked;
        ##1 !class_ok ##1 sync_state != shs_pkg::SHS_LOCKED;
    endsequence

    a_mplane_rf_off: assert property (!mplane_up |=> !rf_tx_enable) // see RULE19
        else $error("RF on while management plane down");

    a_free_kills_rf: assert property ( // see RULE16
        $rose(sync_state == shs_pkg::SHS_FREE) |-> !carrier_active && free_notice ##1 !rf_tx_enable)
        else $error("free-running left carriers or RF on");

    a_carrier_by_req: assert property ( // see RULE16
        $rose(carrier_active) |-> $past(wr_ctrl) && $past(wr_data[`SHS_CTRL_CARRIER]))
        else $error("carrier activated without request");

    a_class_drop: assert property ( // see RULE17
        s_class_reject and sync_state == shs_pkg::SHS_LOCKED |-> s_leave_locked)
        else $error("rejected clock class kept reference");

    a_hold_when_en: assert property ( // see RULE6
        sync_state == shs_pkg::SHS_LOCKED ##1 sync_state == shs_pkg::SHS_HOLD |-> $past(holdover_en))
        else $error("holdover entered while disabled");

    a_hold_bounded: assert property (hold_cnt < HOLD_CYC) // see RULE7
        else $error("holdover outlived its limit");

    a_startup_port: assert property ( // see RULE12
        do_start |=> port_started && port_valid && active_port == $past(pick))
        else $error("startup port not taken");

    a_rf_needs_sync: assert property ( // see RULE20
        rf_tx_enable |-> $past(sync_state) != shs_pkg::SHS_FREE && $past(carrier_active))
        else $error("RF on without sync and carrier");
endmodule : shs_top

// *** src/shs_cfg.svh ***
// constants of the sync holdover supervisor
// Notes on behaviour
// RULE1: unit controller drops all RF when free-running
// RULE2: unit controller may run unsynchronised when bridged
// RULE3: local receiver: unsynchronised running optional
// RULE4: radio ignores controller sync state entirely
// RULE5: radio and controller holdover stay independent
// RULE6: holdover optional; otherwise straight to free-running
// RULE7: short holdover bridges grandmaster switchover
// RULE8: controller weighs accuracy beside sync state
// RULE9: controller monitors radio state and quality
// RULE10: controller may back up frequency and time
// RULE11: grandmaster drives reference on some link
// RULE12: radio accepts reference on any port
// RULE13: reference redundancy across links is optional
// RULE14: domain numbers filtered, defaults 24 and 44
// RULE15: clock classes filtered, defaults 6 and 7
// RULE16: free-running stops RF, carriers off, notify
// RULE17: bad clock class drops reference usage
// RULE18: controller stops IQ on management loss
// RULE19: management loss keeps radio RF off
// RULE20: three-state sync plus accuracy gates RF; accuracy here only reaches the status register
// RULE21: acceptance lists writable, defaults on reset
`ifndef SHS_CFG_SVH
`define SHS_CFG_SVH

`define SHS_ADDR_W 8
`define SHS_PORTS 4
`define SHS_PORT_W 2
`define SHS_SLOTS 8
`define SHS_SLOT_W 3
`define SHS_DOM_SLOTS 2

`define SHS_REG_CTRL 8'h00
`define SHS_REG_STATUS 8'h04
`define SHS_REG_NOTICE 8'h08
`define SHS_REG_LAST 8'h0C
`define SHS_LIST_TAG 3'h1

`define SHS_CTRL_HOLD_EN 0
`define SHS_CTRL_REDUN_EN 1
`define SHS_CTRL_CARRIER 2
`define SHS_NOTICE_FREE 0
`define SHS_SLOT_VALID 8

`define SHS_DOM_FULL 8'h18
`define SHS_DOM_PART 8'h2C
`define SHS_CLS_A 8'h06
`define SHS_CLS_B 8'h07
`define SHS_CLS_C 8'h87
`define SHS_CLS_D 8'h8C
`define SHS_CLS_E 8'h96
`define SHS_CLS_F 8'hA0
`define SHS_CLS_G 8'hF8

`define SHS_CLK_MHZ 100
`define SHS_HOLD_US 1000
`define SHS_HOLD_CYC (`SHS_HOLD_US * `SHS_CLK_MHZ)

`endif

// *** src/shs_pkg.sv ***
// types of the sync holdover supervisor
package shs_pkg;
    typedef enum logic [1:0] {
        SHS_FREE,
        SHS_LOCKED,
        SHS_HOLD
    } shs_state_e;

    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic [7:0] domain;
        logic [7:0] clock_class;
    } shs_ann_s;
endpackage : shs_pkg

// *** src/shs_accept_mem.sv ***
// acceptance list storage for announce domain and clock class
`include "shs_cfg.svh"
module shs_accept_mem (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // software access
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [`SHS_SLOT_W-1:0] idx,
    input wire logic [8:0] wr_data,
    output logic [8:0] rd_data,
    // announce check
    input wire logic chk_valid,
    input wire logic [7:0] chk_domain,
    input wire logic [7:0] chk_class,
    output logic chk_done,
    output logic dom_ok,
    output logic cls_ok
);
    logic [8:0] slot [`SHS_SLOTS];
    logic [`SHS_SLOTS-1:0] hit_dom;
    logic [`SHS_SLOTS-1:0] hit_cls;
    wire is_dom_slot = idx < `SHS_SLOT_W'(`SHS_DOM_SLOTS);
    wire wr_ok = wr_en && (is_dom_slot || class_allowed(wr_data[7:0]));

    // operators may only pick from the fixed set of classes
    function automatic logic class_allowed(input logic [7:0] c);
        class_allowed = (c == `SHS_CLS_A) || (c == `SHS_CLS_B) || (c == `SHS_CLS_C) ||
            (c == `SHS_CLS_D) || (c == `SHS_CLS_E) || (c == `SHS_CLS_F) ||
            (c == `SHS_CLS_G); // see RULE15
    endfunction : class_allowed

    always_comb begin
        for (int i = 0; i < `SHS_SLOTS; i++) begin
            hit_dom[i] = (i < `SHS_DOM_SLOTS) && slot[i][`SHS_SLOT_VALID] &&
                (slot[i][7:0] == chk_domain); // see RULE14
            hit_cls[i] = (i >= `SHS_DOM_SLOTS) && slot[i][`SHS_SLOT_VALID] &&
                (slot[i][7:0] == chk_class); // see RULE15
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `SHS_SLOTS; i++) begin
                slot[i] <= 9'h000;
            end
            slot[0] <= {1'b1, `SHS_DOM_FULL}; // see RULE21
            slot[1] <= {1'b1, `SHS_DOM_PART}; // see RULE14
            slot[2] <= {1'b1, `SHS_CLS_A}; // see RULE15
            slot[3] <= {1'b1, `SHS_CLS_B};
        end else if (wr_ok) begin
            slot[idx] <= wr_data; // see RULE21
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= 9'h000;
            chk_done <= 1'b0;
            dom_ok <= 1'b0;
            cls_ok <= 1'b0;
        end else begin
            rd_data <= rd_en ? slot[idx] : 9'h000;
            chk_done <= chk_valid;
            dom_ok <= |hit_dom;
            cls_ok <= |hit_cls;
        end
    end

    a_default_lists: assert property (@(posedge core_clk) // see RULE21
        $past(sys_rst) && !sys_rst |-> slot[0] == {1'b1, `SHS_DOM_FULL} &&
            slot[3] == {1'b1, `SHS_CLS_B})
        else $error("acceptance lists not at defaults after reset");

    a_class_filter: assert property (@(posedge core_clk) disable iff (sys_rst) // see RULE15
        chk_valid && !(|hit_cls) |=> chk_done && !cls_ok)
        else $error("unlisted clock class accepted");
endmodule : shs_accept_mem

// *** tb/shs_du_model.sv ***
// model of the controller side: management link and announce source
module shs_du_model (
    // clock
    input wire logic core_clk,
    // toward the radio
    output logic mplane_up,
    output shs_pkg::shs_ann_s announce
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        mplane_up = 1'b1;
        announce = 19'h0;
    end

    // one announce on one link; fields flip once valid drops so stale data never matches
    task automatic send(input logic [1:0] p, input logic [7:0] d, input logic [7:0] c);
        announce <= {1'b1, p, d, c};
        @(posedge core_clk);
        announce <= {1'b0, ~p, ~d, ~c};
        @(posedge core_clk);
    endtask : send

    // link drop: controller issues no carrier request while down
    task automatic link(input logic up);
        mplane_up <= up;
        @(posedge core_clk);
    endtask : link
endmodule : shs_du_model

// *** tb/tb_top.sv ***
// self-checking bench of the sync holdover supervisor
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rd_data;
    logic ref_locked = 1'b0;
    logic accuracy_ok = 1'b0;
    logic mplane_up;
    shs_pkg::shs_ann_s announce;
    logic [3:0] sync_present = 4'h4;
    logic rf_tx_enable, carrier_active, free_notify, port_valid;
    shs_pkg::shs_state_e sync_state;
    logic [1:0] active_port;
    logic rd_pend = 1'b0;
    logic [63:0] note_q[$];
    logic [63:0] note;
    logic [31:0] lfsr = 32'h00012700;
    logic [8:0] dflt[8] = '{9'h118, 9'h12C, 9'h106, 9'h107, 9'h0, 9'h0, 9'h0, 9'h0};
    logic [7:0] cls[7] = '{8'h06, 8'h07, 8'h87, 8'h8C, 8'h96, 8'hA0, 8'hF8};
    int error_cnt = 0;
    int check_count = 0;
    // rf, carrier, notify, port_valid, locked, hold, free, port one
    wire [7:0] flag_w = {active_port == 2'h1, sync_state == shs_pkg::SHS_FREE,
        sync_state == shs_pkg::SHS_HOLD, sync_state == shs_pkg::SHS_LOCKED,
        port_valid, free_notify, carrier_active, rf_tx_enable};

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    shs_du_model du (
        .core_clk(core_clk),
        .mplane_up(mplane_up),
        .announce(announce)
    );

    shs_top #(.HOLD_CYC(20)) dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .ref_locked(ref_locked),
        .accuracy_ok(accuracy_ok),
        .mplane_up(mplane_up),
        .announce(announce),
        .sync_present(sync_present),
        .rf_tx_enable(rf_tx_enable),
        .carrier_active(carrier_active),
        .free_notify(free_notify),
        .sync_state(sync_state),
        .active_port(active_port),
        .port_valid(port_valid)
    );

    function automatic logic [31:0] lfsr_step(input logic [31:0] v);
        lfsr_step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_step

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // idle cycle after each strobe so no strobe is driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        note_q.push_back({m, e & m});
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    task automatic wait_flag(input int i, input logic v, input int lim);
        int n = 0;
        while (flag_w[i] !== v && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        chk(flag_w[i], v);
        if (flag_w[i] !== v) begin
            close_out();
        end
    endtask : wait_flag

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        rd_pend <= rd_en;
        if (rd_pend) begin
            note = note_q.pop_front();
            chk(rd_data & note[63:32], note[31:0]);
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'h20 + 8'(4 * i), 32'(dflt[i]), 32'h1FF);
        end
        lfsr = lfsr_step(lfsr);
        rd(8'h40 + {2'h0, lfsr[5:0]}, 32'h0, 32'hFFFFFFFF);
        wait_flag(3, 1'b1, 10);
        chk(active_port, 2'h2);
        rd(8'h04, 32'h190, 32'h3FF);
        $display("test reset and port done");
        ref_locked <= 1'b1;
        accuracy_ok <= 1'b1;
        wr(8'h00, 32'h5);
        rd(8'h00, 32'h1, 32'h7);
        lfsr = lfsr_step(lfsr);
        du.send(2'h2, lfsr[7:0] | 8'h80, 8'h06);
        repeat (4) @(posedge core_clk);
        chk(flag_w[6], 1'b1);
        du.send(2'h2, 8'h18, 8'h06);
        wait_flag(4, 1'b1, 6);
        rd(8'h04, 32'h399, 32'h3FF);
        du.send(2'h1, 8'h18, 8'h8C);
        repeat (4) @(posedge core_clk);
        chk(flag_w[4], 1'b1);
        rd(8'h0C, 32'h1806, 32'hFFFF);
        wr(8'h00, 32'h5);
        wait_flag(0, 1'b1, 4);
        $display("test lock done");
        du.link(1'b0);
        wait_flag(0, 1'b0, 2);
        repeat (5) @(posedge core_clk);
        chk(flag_w[0], 1'b0);
        chk(flag_w[4], 1'b1);
        du.link(1'b1);
        wait_flag(0, 1'b1, 3);
        $display("test management link done");
        du.send(2'h2, 8'h2C, 8'h8C);
        wait_flag(5, 1'b1, 6);
        repeat (12) @(posedge core_clk);
        chk({flag_w[5], flag_w[0]}, 2'h3);
        wait_flag(2, 1'b1, 12);
        chk({flag_w[6], flag_w[1]}, 2'h2);
        wait_flag(0, 1'b0, 2);
        rd(8'h08, 32'h1, 32'h1);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h0, 32'h1);
        $display("test holdover done");
        wr(8'h3C, 32'h164);
        rd(8'h3C, 32'h0, 32'h1FF);
        foreach (cls[i]) begin
            wr(8'h3C, {23'h0, 1'b1, cls[i]});
            rd(8'h3C, {23'h0, 1'b1, cls[i]}, 32'h1FF);
        end
        du.send(2'h2, 8'h18, 8'hF8);
        wait_flag(4, 1'b1, 6);
        chk(flag_w[1], 1'b0);
        wr(8'h00, 32'h4);
        wait_flag(0, 1'b1, 4);
        du.send(2'h2, 8'h18, 8'h96);
        wait_flag(2, 1'b1, 6);
        chk(flag_w[6], 1'b1);
        $display("test lists and no holdover done");
        sync_present <= 4'h6;
        wr(8'h00, 32'h2);
        sync_present <= 4'h2;
        wait_flag(7, 1'b1, 10);
        chk(flag_w[3], 1'b1);
        wr(8'h00, 32'h0);
        sync_present <= 4'h0;
        wait_flag(3, 1'b0, 10);
        $display("test redundancy done");
        close_out();
    end
endmodule : tb_top
